// ==== core/aomc_pkg.sv ====
// Constants and types of the operating-mode control register.
// Assumes a serial configuration port with 8 address and 16 data bits.
package aomc_pkg;

  // ----------------------------------------------------------------------
  // Serial frame and register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_BITS      = 8;
  localparam int          DATA_BITS      = 16;
  localparam int          FRAME_BITS     = ADDR_BITS + DATA_BITS;
  localparam logic [6:0]  CTRL_ADDR      = 7'h01;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  // Bits that are stored: 12 and 10..0; reserved and unused read zero
  localparam logic [15:0] CTRL_KEEP_MASK = 16'h17ff;

  // ----------------------------------------------------------------------
  // Field layout of the control word, msb first
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] unused;
    logic       reserved_13;
    logic       test_mode;
    logic       reserved_11;
    logic       full_scale_select;
    logic [1:0] bandwidth_select;
    logic       gray_code;
    logic       demux_ratio;
    logic [1:0] standby_field;
    logic [3:0] channel_mode_select;
  } aomc_ctrl_type;

  // Channel arrangement, Gray coded
  typedef enum logic [1:0] {
    MODE_FOUR   = 2'b00,
    MODE_TWO    = 2'b01,
    MODE_ONE    = 2'b11,
    MODE_COMMON = 2'b10
  } aomc_mode_type;

  // Decoded settings handed to the analog side
  typedef struct packed {
    aomc_mode_type mode;
    logic [1:0]    input_sel;
    logic [3:0]    core_standby;
    logic          demux_ratio;
    logic          gray_code;
    logic [1:0]    bandwidth_select;
    logic          full_scale_select;
    logic          test_mode;
  } aomc_cfg_type;

endpackage

// ==== core/aomc_core.sv ====
// Operating-mode control register behind the serial configuration port.
// Assumes all serial pins are asynchronous to ref_clk and that the serial
// clock is slower than ref_clk / 8 so every edge is seen after sync.
// How it works
// - Mode codes 00xx give four independent channels; reset value is zero.
// - Codes 0100..0111 interleave pairs A+C, B+C, A+D, B+D.
// - Codes 10xx interleave all cores; low bits pick input A..D.
// - Codes 11xx feed one input to all cores; low bits pick it.
// - Standby 01 idles A and B, or the used one of A/B.
// - Standby 10 idles C and D, or the used one of C/D.
// - Standby 11 idles every core; 00 keeps all active.
// - In single or common mode any nonzero standby idles all cores.
// - Bit 6 picks demux ratio: zero is 1:2, one is 1:1.
// - Bit 7 picks output code: zero binary, one Gray.
// - Bits 9..8 pick bandwidth: minimum, reduced, nominal, full.
// - Bit 10 picks input range: 500 or 625 mVpp.
// - Bit 12 enables test pattern output; zero is normal conversion.
`timescale 1ns/10ps

module aomc_core
  import aomc_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         srst,
  // Serial configuration pins
  input  wire logic         spi_sclk,
  input  wire logic         spi_cs_n,
  input  wire logic         spi_mosi,
  input  wire logic         spi_rst_n,
  output logic              spi_miso,
  // Decoded settings
  output aomc_cfg_type      cfg
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0]    pin_meta;
  logic [3:0]    pin_sync;
  logic          sclk_prev;
  logic [22:0]   shift_in;
  logic [4:0]    bit_cnt;
  logic [15:0]   tx_shift;
  aomc_ctrl_type ctrl;

  // Order {rstn, csn, sclk, mosi}; the first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_meta <= 4'h4;
      pin_sync <= 4'h4;
    end else begin
      pin_meta <= {spi_rst_n, spi_cs_n, spi_sclk, spi_mosi};
      pin_sync <= pin_meta;
    end
  end

  wire mosi_s  = pin_sync[0];
  wire sclk_s  = pin_sync[1];
  wire cs_n_s  = pin_sync[2];
  wire rstn_s  = pin_sync[3];

  // ----------------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------------
  // Edges of the synchronised serial clock, only inside a frame
  wire sclk_rise = sclk_s & ~sclk_prev & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_prev & ~cs_n_s;

  // Eighth bit closes the address; shift_in[6] is then the R/W bit
  wire addr_done = sclk_rise && (bit_cnt == 5'(ADDR_BITS - 1));
  wire addr_hit  = ({shift_in[5:0], mosi_s} == CTRL_ADDR);
  wire frame_end = sclk_rise && (bit_cnt == 5'(FRAME_BITS - 1));
  // R/W one and our address give a write of the data that follows
  wire write_hit = frame_end && shift_in[22]
                   && (shift_in[21:15] == CTRL_ADDR);
  wire [15:0] write_word = {shift_in[14:0], mosi_s};

  // Reserved and unused bits are not stored, so a stray one is harmless
  wire [15:0] next_ctrl = write_word & CTRL_KEEP_MASK;
  wire [15:0] read_word = addr_hit ? (ctrl & CTRL_KEEP_MASK) : 16'h0000;
  // Data leaves msb first, shifted on falling edges of the data phase
  wire        tx_step   = sclk_fall && (bit_cnt > 5'(ADDR_BITS));

  // Bit counter and input shifter; idle chip select restarts a frame
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclk_prev <= 1'b0;
      shift_in  <= '0;
      bit_cnt   <= 5'h00;
    end else begin
      sclk_prev <= sclk_s;
      if (cs_n_s) begin
        shift_in <= '0;
        bit_cnt  <= 5'h00;
      end else if (sclk_rise && bit_cnt != 5'(FRAME_BITS)) begin
        shift_in <= {shift_in[21:0], mosi_s};
        bit_cnt  <= bit_cnt + 5'h01;
      end
    end
  end

  // Read data loads at the end of the address so the first bit is early
  always_ff @(posedge ref_clk) begin
    if (srst || cs_n_s) begin
      tx_shift <= 16'h0000;
    end else if (addr_done && !shift_in[6]) begin
      tx_shift <= read_word;
    end else if (tx_step) begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  // Output is never floated; it idles low between frames
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      spi_miso <= 1'b0;
    end else begin
      spi_miso <= tx_shift[15];
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // Serial reset pin clears like srst; a write lands on the last bit
  always_ff @(posedge ref_clk) begin
    if (srst || !rstn_s) begin
      ctrl <= aomc_ctrl_type'(CTRL_RESET);
    end else if (write_hit) begin
      ctrl <= aomc_ctrl_type'(next_ctrl);
    end
  end

  // ----------------------------------------------------------------------
  // Mode and standby decode
  // ----------------------------------------------------------------------
  wire [1:0] mode_hi = ctrl.channel_mode_select[3:2];
  wire [1:0] sel     = ctrl.channel_mode_select[1:0];
  wire [1:0] standby_code = ctrl.standby_field;
  wire       is_four = (mode_hi == 2'b00);
  wire       is_two  = (mode_hi == 2'b01);
  wire       is_wide = mode_hi[1];
  aomc_mode_type next_mode;
  assign next_mode = is_four ? MODE_FOUR :
                     is_two  ? MODE_TWO  :
                     (mode_hi == 2'b10) ? MODE_ONE :
                     MODE_COMMON;
  logic [3:0] next_standby;

  // Per core: A,B form the low half, C,D the high half
  for (genvar i = 0; i < 4; i++) begin : g_core
    localparam logic [1:0] IDX = 2'(i);
    // Used in a pair when the pick bit of its half names it
    wire in_use = IDX[1] ? (sel[1] == IDX[0]) : (sel[0] == IDX[0]);
    assign next_standby[i] = (standby_code == 2'b11)
                          || (is_wide && standby_code != 2'b00)
                          || (is_four && standby_code[IDX[1]])
                          || (is_two && in_use && standby_code[IDX[1]]);
  end

  aomc_cfg_type next_cfg;
  assign next_cfg = '{mode:              next_mode,
                      input_sel:         sel,
                      core_standby:      next_standby,
                      demux_ratio:       ctrl.demux_ratio,
                      gray_code:         ctrl.gray_code,
                      bandwidth_select:  ctrl.bandwidth_select,
                      full_scale_select: ctrl.full_scale_select,
                      test_mode:         ctrl.test_mode};

  // Registered so every output comes straight from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_write;
    write_hit ##1 1'b1;
  endsequence
  // Word clears first, the decoded outputs follow one edge later
  sequence s_cleared;
    ctrl == aomc_ctrl_type'(CTRL_RESET) ##1 cfg == '0;
  endsequence

  property p_four;
    is_four |=> cfg.mode == MODE_FOUR;
  endproperty
  a_four: assert property (p_four)
    else $error("four-channel code not decoded");

  property p_two;
    is_two |=> cfg.mode == MODE_TWO && cfg.input_sel == $past(sel);
  endproperty
  a_two: assert property (p_two)
    else $error("pair code not decoded");

  property p_one;
    mode_hi == 2'b10 |=> cfg.mode == MODE_ONE;
  endproperty
  a_one: assert property (p_one)
    else $error("single channel code not decoded");

  property p_common;
    mode_hi == 2'b11 |=> cfg.mode == MODE_COMMON;
  endproperty
  a_common: assert property (p_common)
    else $error("common input code not decoded");

  property p_standby_ab;
    is_four && standby_code == 2'b01 |=> cfg.core_standby == 4'h3;
  endproperty
  a_standby_ab: assert property (p_standby_ab)
    else $error("standby of A and B wrong");

  property p_standby_cd;
    is_two && standby_code == 2'b10 |=> $countones(cfg.core_standby) == 1
                                        && cfg.core_standby[3:2] != 2'b00;
  endproperty
  a_standby_cd: assert property (p_standby_cd)
    else $error("pair standby of C or D wrong");

  property p_standby_full;
    standby_code == 2'b11 |=> cfg.core_standby == 4'hf;
  endproperty
  a_standby_full: assert property (p_standby_full)
    else $error("full standby not applied");

  property p_wide_standby;
    is_wide |=> (cfg.core_standby == 4'hf)
                == ($past(standby_code) != 2'b00);
  endproperty
  a_wide_standby: assert property (p_wide_standby)
    else $error("wide mode standby wrong");

  property p_fields;
    1'b1 |=> cfg.bandwidth_select == $past(ctrl.bandwidth_select)
             && cfg.test_mode == $past(ctrl.test_mode)
             && cfg.gray_code == $past(ctrl.gray_code)
             && cfg.demux_ratio == $past(ctrl.demux_ratio)
             && cfg.full_scale_select == $past(ctrl.full_scale_select);
  endproperty
  a_fields: assert property (p_fields)
    else $error("field not passed to output");

  property p_commit;
    s_write |-> ctrl == aomc_ctrl_type'($past(next_ctrl)) ##1
                cfg.test_mode == ctrl.test_mode;
  endproperty
  a_commit: assert property (p_commit)
    else $error("write did not reach outputs");

  property p_spi_reset;
    !rstn_s |=> s_cleared;
  endproperty
  a_spi_reset: assert property (p_spi_reset)
    else $error("serial reset did not clear register");

endmodule

// ==== testbench/aomc_host.sv ====
// Host model that drives the serial configuration pins of the device.
// Assumes ref_clk at 125 MHz; mode 0 frames; sclk stands low between frames.
`timescale 1ns/10ps

module aomc_host (
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  input  wire logic spi_miso,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  output logic      spi_rst_n
);
  // ----------------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------------
  // Half period well above the 2 cycles the pin synchronisers need
  localparam int HALF = 8;

  // Idle levels at time zero
  initial begin
    spi_sclk  = 1'b0;
    spi_cs_n  = 1'b1;
    spi_mosi  = 1'b0;
    spi_rst_n = 1'b1;
  end

  // Frame of nbits bits, msb first; fewer than 24 aborts it
  task automatic frame(input logic [23:0] word, input int nbits,
                       output logic [15:0] rdata);
    rdata = 16'h0000;
    @(posedge ref_clk) spi_cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi <= word[23-i];
      repeat (HALF) @(posedge ref_clk);
      if (i >= 8) rdata = {rdata[14:0], spi_miso};
      spi_sclk <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
      spi_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge ref_clk);
    spi_cs_n <= 1'b1;
    // A released data line must not keep showing its last bit
    spi_mosi <= ~spi_mosi;
    repeat (4) @(posedge ref_clk);
  endtask

  // Serial-port reset pulse, long enough to pass the synchroniser
  task automatic pulse_reset();
    @(posedge ref_clk) spi_rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    spi_rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// ==== testbench/aomc_core_test.sv ====
// Self-checking bench of the operating-mode control register.
// Assumes the host model owns every serial pin of the device.
`timescale 1ns/10ps

module aomc_core_test
  import aomc_pkg::*;
();
  logic         ref_clk;
  logic         srst;
  logic         spi_sclk;
  logic         spi_cs_n;
  logic         spi_mosi;
  logic         spi_rst_n;
  logic         spi_miso;
  aomc_cfg_type cfg;
  logic [15:0]  rdata;
  logic [15:0]  cur;
  logic [31:0]  r;
  int           failures = 0;
  int           checks_done = 0;

  // ----------------------------------------------------------------------
  // Device and host
  // ----------------------------------------------------------------------
  aomc_core i_dut (.ref_clk(ref_clk), .srst(srst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_rst_n(spi_rst_n),
    .spi_miso(spi_miso), .cfg(cfg));
  aomc_host i_host (.ref_clk(ref_clk), .spi_miso(spi_miso),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_rst_n(spi_rst_n));

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  // Expected decode of a stored control word
  function automatic aomc_cfg_type expect_cfg(input logic [15:0] w);
    aomc_cfg_type e;
    logic [1:0]   sb;
    sb = w[5:4];
    e = '0;
    e.mode = (w[3:2] == 2'b00) ? MODE_FOUR : (w[3:2] == 2'b01) ? MODE_TWO :
             (w[3:2] == 2'b10) ? MODE_ONE : MODE_COMMON;
    e.input_sel = w[1:0];
    // Single and common modes take any nonzero code as full standby
    if (sb == 2'b11 || (w[3] && sb != 2'b00)) e.core_standby = 4'hf;
    else if (!w[2]) e.core_standby = {{2{sb[1]}}, {2{sb[0]}}};
    else e.core_standby = {sb[1] & w[1], sb[1] & ~w[1],
                           sb[0] & w[0], sb[0] & ~w[0]};
    e.demux_ratio = w[6];
    e.gray_code = w[7];
    e.bandwidth_select = w[9:8];
    e.full_scale_select = w[10];
    e.test_mode = w[12];
    return e;
  endfunction

  task automatic check_cfg(input aomc_cfg_type exp);
    checks_done++;
    if (cfg !== exp) begin
      failures++;
      $display("mismatch at %0t: cfg %h expected %h", $time, cfg, exp);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  // One frame, then time for the commit to reach cfg
  task automatic access(input logic rw, input logic [6:0] addr,
                        input logic [15:0] data, input int nbits);
    i_host.frame({rw, addr, data}, nbits, rdata);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    void'($urandom(95058));
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check_cfg('0);
    access(1'b0, CTRL_ADDR, 16'h0000, 24);
    check_word(rdata, CTRL_RESET);
    // Every mode and standby code, other stored bits random
    for (int k = 0; k < 65; k++) begin
      r = $urandom;
      cur = {3'b000, r[5], 1'b0, r[4:0], 6'(k)};
      if (k == 64) cur = CTRL_KEEP_MASK;
      access(1'b1, CTRL_ADDR, cur, 24);
      check_cfg(expect_cfg(cur));
      access(1'b0, CTRL_ADDR, 16'h0000, 24);
      check_word(rdata, cur);
    end
    // Other address and short frame leave the word alone
    access(1'b1, 7'h02, 16'h0a5a, 24);
    access(1'b1, CTRL_ADDR, 16'h0000, 20);
    check_cfg(expect_cfg(cur));
    access(1'b0, 7'h02, 16'h0000, 24);
    check_word(rdata, 16'h0000);
    // Serial-port reset clears the word and its decode
    i_host.pulse_reset();
    check_cfg('0);
    access(1'b0, CTRL_ADDR, 16'h0000, 24);
    check_word(rdata, CTRL_RESET);
    test_done();
  end

  // Watchdog: the sequence needs about 55000 cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
